// *** inc/tlic_pkg.sv ***
// constants for the two-level interrupt controller: offsets, fields, timing
// assumes a 40 MHz core clock; one machine cycle is twelve pclk edges with ce high
package tlic_pkg;

    // machine cycle: six states of two phases
    localparam int           PHASES_PER_MC = 12;
    localparam logic [3:0]   PHASE_LAST    = 4'hB;   // state6 phase2
    localparam logic [3:0]   PHASE_SAMPLE  = 4'h9;   // state5_phase2
    localparam int           NUM_SRC       = 6;
    localparam int           HW_CALL_MCS   = 2;      // long_call length in machine cycles

    // apb register byte offsets
    localparam logic [7:0]   OFS_ENABLE    = 8'h00;  // irq_enable_reg
    localparam logic [7:0]   OFS_LEVEL     = 8'h04;  // irq_level_reg
    localparam logic [7:0]   OFS_TCTRL     = 8'h08;  // timer_ctrl_reg
    localparam logic [7:0]   OFS_T2CTRL    = 8'h0C;  // timer 2 pin control
    localparam logic [7:0]   OFS_STATUS    = 8'h10;  // read-only state

    // irq_enable_reg fields: bits 5..0 per source, bit 7 global
    localparam int           EN_GLOBAL     = 7;
    // timer_ctrl_reg fields
    localparam int           TC_EXT0_SEL   = 0;
    localparam int           TC_EXT0_FLAG  = 1;
    localparam int           TC_EXT1_SEL   = 2;
    localparam int           TC_EXT1_FLAG  = 3;
    localparam int           TC_TMR0_FLAG  = 5;
    localparam int           TC_TMR1_FLAG  = 7;
    // timer 2 pin control fields
    localparam int           T2_PIN_EN     = 0;
    localparam int           T2_PIN_FLAG   = 1;
    // status fields
    localparam int           ST_INPROG_LO  = 0;
    localparam int           ST_INPROG_HI  = 1;
    localparam int           ST_CALL       = 2;
    localparam int           ST_VEC_LSB    = 8;

    // source index in polling order
    localparam logic [2:0]   SRC_EXT0      = 3'h0;
    localparam logic [2:0]   SRC_TMR0      = 3'h1;
    localparam logic [2:0]   SRC_EXT1      = 3'h2;
    localparam logic [2:0]   SRC_TMR1      = 3'h3;
    localparam logic [2:0]   SRC_SERIAL    = 3'h4;
    localparam logic [2:0]   SRC_TMR2      = 3'h5;

    // vector addresses, indexed by source
    localparam logic [15:0]  VEC_BASE      = 16'h0003;
    localparam logic [15:0]  VEC_STEP      = 16'h0008;

    // reset values
    localparam logic [7:0]   RST_ENABLE    = 8'h00;
    localparam logic [5:0]   RST_LEVEL     = 6'h00;

    // hardware call sequencer, one-hot
    typedef enum logic [2:0] {
        TLIC_POLL  = 3'b001,
        TLIC_CALL1 = 3'b010,
        TLIC_CALL2 = 3'b100
    } tlic_seq_t;

endpackage

// *** design/tlic_core.sv ***
// two-level priority interrupt controller with apb register access
// assumes the cpu sequencer flags the final cycle of each instruction and
// return_from_irq on pclk; request pins and the timer 2 pin are asynchronous
//
// Summary of operation
// - low-level routine preempted only by high level; high-level routine never preempted.
// - with both levels pending in one poll, the high-level request wins.
// - within a level, fixed order: ext0, tmr0, ext1, tmr1, serial, tmr2.
// - flags sampled at state5_phase2, examined in the following machine cycle.
// - no vector if level busy, not last instruction cycle, or return_from_irq/enable/level write.
// - after an enable/level write one more instruction completes first; after return_from_irq, two more.
// - blocked requests are not remembered; each poll sees only current flags.
// - external flags cleared on vectoring only in edge mode; level mode follows pin.
// - hardware call pushes program counter only, then loads the source vector.
// - vectors 0003h, 000Bh, 0013h, 001Bh, 0023h, 002Bh in polling order.
// - return_from_irq clears the current in-progress level, then pops the return address.
// - a plain subroutine_exit leaves the in-progress level marked.
// - edge select 0 low level requests; 1 high-then-low samples set flag.
// - timer 2 pin falling edge sets its event flag only while pin enable set.
// - hardware call lasts two machine cycles, three minimum from request to routine.
// - single-source latency more than 3 and less than 9 machine cycles.
// - timer 0/1 overflow flags set on rollover, cleared on vectoring.
// - serial and timer 2 flags ORed per source, never cleared on vectoring.
// - a priority bit per source: 0 low level, 1 high level.
`timescale 1ns/10ps
`default_nettype none

module tlic_core
    import tlic_pkg::*;
(
    // clock, reset, freeze
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          ce,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // asynchronous pins
    input  wire logic [1:0]    ext_request_pin,
    input  wire logic          tmr2_capture_pin,
    // peripheral flags, same clock
    input  wire logic          tmr0_rollover,
    input  wire logic          tmr1_rollover,
    input  wire logic          rx_done_flag,
    input  wire logic          tx_done_flag,
    input  wire logic          tmr2_ovf_flag,
    // cpu sequencer
    input  wire logic          instr_last_cycle,
    input  wire logic          return_from_irq,
    output logic               long_call,
    output logic [15:0]        call_vector,
    output logic [3:0]         machine_phase,
    output logic [1:0]         in_service
);
    import tlic_pkg::*;

    typedef struct packed {
        logic [3:0]  phase;
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic [2:0]  pin_smp;
        logic [1:0]  edge_sel;
        logic [1:0]  ext_flag;
        logic [1:0]  tmr_flag;
        logic        t2pin_en;
        logic        t2pin_flag;
        logic [7:0]  enable;
        logic [5:0]  level;
        logic [5:0]  smp_req;
        logic [5:0]  poll_req;
        logic [1:0]  inprog;
        logic        hold_off;
        tlic_seq_t   seq;
        logic [15:0] vector;
        logic [31:0] rdata;
    } tlic_state_t;

    tlic_state_t cur;
    tlic_state_t next_cur;

    // first set bit in polling order, lowest index wins
    // an empty mask yields the last source; callers gate on a nonzero mask
    function automatic logic [2:0] tlic_first(input logic [5:0] req);
        logic [2:0] idx;
        idx = SRC_TMR2;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // register read image
    function automatic logic [31:0] tlic_read(input tlic_state_t s, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            OFS_ENABLE: d[7:0] = s.enable;
            OFS_LEVEL:  d[5:0] = s.level;
            OFS_TCTRL: begin
                d[TC_EXT0_SEL]  = s.edge_sel[0];
                d[TC_EXT0_FLAG] = s.ext_flag[0];
                d[TC_EXT1_SEL]  = s.edge_sel[1];
                d[TC_EXT1_FLAG] = s.ext_flag[1];
                d[TC_TMR0_FLAG] = s.tmr_flag[0];
                d[TC_TMR1_FLAG] = s.tmr_flag[1];
            end
            OFS_T2CTRL: begin
                d[T2_PIN_EN]   = s.t2pin_en;
                d[T2_PIN_FLAG] = s.t2pin_flag;
            end
            OFS_STATUS: begin
                d[ST_INPROG_LO] = s.inprog[0];
                d[ST_INPROG_HI] = s.inprog[1];
                d[ST_CALL]      = (s.seq != TLIC_POLL);
                d[ST_VEC_LSB +: 8] = s.vector[7:0];
            end
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // bus decode
    logic        addr_ok;
    logic        wr_en;
    logic        rd_setup;
    logic [5:0]  src_req;
    logic [5:0]  cand;
    logic [5:0]  cand_hi;
    logic [5:0]  cand_lo;
    logic        take_hi;
    logic        take_lo;
    logic        may_vector;
    logic [2:0]  pick;
    logic        mc_end;
    logic        at_sample;
    logic [1:0]  ext_level_req;
    logic [1:0]  ext_fall;
    logic        t2_fall;
    logic        write_ctl;

    assign addr_ok  = (paddr == OFS_ENABLE) || (paddr == OFS_LEVEL) ||
                      (paddr == OFS_TCTRL)  || (paddr == OFS_T2CTRL) ||
                      (paddr == OFS_STATUS);
    // a frozen block cannot take a write, so the access waits for ce
    assign pready   = ce;
    assign pslverr  = psel & penable & ~addr_ok;
    assign wr_en    = psel & penable & pwrite & ce & addr_ok;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign prdata   = cur.rdata;

    // machine cycle timing
    assign mc_end    = (cur.phase == PHASE_LAST);
    assign at_sample = (cur.phase == PHASE_SAMPLE);

    // pin conditions between successive state5_phase2 samples
    assign ext_level_req = ~cur.sync2[1:0];
    assign ext_fall      = cur.pin_smp[1:0] & ~cur.sync2[1:0];
    assign t2_fall       = cur.pin_smp[2] & ~cur.sync2[2];

    // per-source request lines in polling order
    always_comb begin
        src_req[SRC_EXT0]   = cur.ext_flag[0];
        src_req[SRC_TMR0]   = cur.tmr_flag[0];
        src_req[SRC_EXT1]   = cur.ext_flag[1];
        src_req[SRC_TMR1]   = cur.tmr_flag[1];
        src_req[SRC_SERIAL] = rx_done_flag | tx_done_flag;
        src_req[SRC_TMR2]   = tmr2_ovf_flag | cur.t2pin_flag;
    end

    // poll: enabled candidates split by level
    assign cand    = cur.poll_req & cur.enable[5:0] & {6{cur.enable[EN_GLOBAL]}};
    assign cand_hi = cand & cur.level;
    assign cand_lo = cand & ~cur.level;
    // high level blocked only by high in progress, low by any
    assign take_hi = (cand_hi != 6'h00) && !cur.inprog[1];
    assign take_lo = (cand_lo != 6'h00) && (cur.inprog == 2'b00) && !take_hi;
    // a control write in this very cycle blocks too, not only the hold-off after it
    assign may_vector = mc_end && (cur.seq == TLIC_POLL) && instr_last_cycle &&
                        !cur.hold_off && !return_from_irq &&
                        !write_ctl;
    assign pick = take_hi ? tlic_first(cand_hi) : tlic_first(cand_lo);
    assign write_ctl = wr_en && ((paddr == OFS_ENABLE) || (paddr == OFS_LEVEL));

    // next state
    always_comb begin
        next_cur = cur;
        // synchronisers; first stage feeds only the second
        next_cur.sync1 = {tmr2_capture_pin, ext_request_pin};
        next_cur.sync2 = cur.sync1;
        next_cur.phase = mc_end ? 4'h0 : cur.phase + 4'h1;

        // read data captured in the setup phase
        if (rd_setup) begin
            next_cur.rdata = tlic_read(cur, paddr);
        end

        // software writes; hardware sets below win over a clear
        if (wr_en) begin
            unique case (paddr)
                OFS_ENABLE: next_cur.enable = pwdata[7:0];
                OFS_LEVEL:  next_cur.level  = pwdata[5:0];
                OFS_TCTRL: begin
                    next_cur.edge_sel[0] = pwdata[TC_EXT0_SEL];
                    next_cur.edge_sel[1] = pwdata[TC_EXT1_SEL];
                    next_cur.ext_flag[0] = pwdata[TC_EXT0_FLAG];
                    next_cur.ext_flag[1] = pwdata[TC_EXT1_FLAG];
                    next_cur.tmr_flag[0] = pwdata[TC_TMR0_FLAG];
                    next_cur.tmr_flag[1] = pwdata[TC_TMR1_FLAG];
                end
                OFS_T2CTRL: begin
                    next_cur.t2pin_en   = pwdata[T2_PIN_EN];
                    next_cur.t2pin_flag = pwdata[T2_PIN_FLAG];
                end
                default: ;
            endcase
        end

        // enable or level change holds off vectoring for one instruction
        // the clear waits for an instruction end, never a bare machine-cycle end
        if (write_ctl || return_from_irq) begin
            next_cur.hold_off = 1'b1;
        end else if (mc_end && instr_last_cycle) begin
            next_cur.hold_off = 1'b0;
        end

        // hardware clear on vectoring, before the sets so a new event survives
        // edge-mode ext flags clear here or on a timer_ctrl_reg write; a level flag is rebuilt from its pin
        if (may_vector && (take_hi || take_lo)) begin
            next_cur.seq    = TLIC_CALL1;
            next_cur.vector = VEC_BASE + VEC_STEP * 16'(pick);
            if (take_hi) begin
                next_cur.inprog[1] = 1'b1;
            end else begin
                next_cur.inprog[0] = 1'b1;
            end
            unique case (pick)
                SRC_EXT0: if (cur.edge_sel[0]) next_cur.ext_flag[0] = 1'b0;
                SRC_EXT1: if (cur.edge_sel[1]) next_cur.ext_flag[1] = 1'b0;
                SRC_TMR0: next_cur.tmr_flag[0] = 1'b0;
                SRC_TMR1: next_cur.tmr_flag[1] = 1'b0;
                default: ;                                 // serial, timer 2
            endcase
        end else if (mc_end) begin
            unique case (cur.seq)
                TLIC_POLL:  next_cur.seq = TLIC_POLL;
                TLIC_CALL1: next_cur.seq = TLIC_CALL2;
                TLIC_CALL2: next_cur.seq = TLIC_POLL;
                default:    next_cur.seq = TLIC_POLL;
            endcase
        end

        // return_from_irq drops the highest level in progress only
        // a plain subroutine_exit never comes here, so its level stays marked
        if (return_from_irq && mc_end && instr_last_cycle) begin
            if (cur.inprog[1]) begin
                next_cur.inprog[1] = 1'b0;
            end else begin
                next_cur.inprog[0] = 1'b0;
            end
        end

        // pin sampling at state5_phase2
        if (at_sample) begin
            next_cur.pin_smp = cur.sync2;
            for (int x = 0; x < 2; x++) begin
                if (!cur.edge_sel[x]) begin
                    next_cur.ext_flag[x] = ext_level_req[x];
                end else if (ext_fall[x]) begin
                    next_cur.ext_flag[x] = 1'b1;
                end
            end
            if (t2_fall && cur.t2pin_en) begin
                next_cur.t2pin_flag = 1'b1;
            end
            // latch request lines; only this snapshot is ever polled. pin flags
            // come from this same sample, so a pin event is polled next cycle
            next_cur.smp_req           = src_req;
            next_cur.smp_req[SRC_EXT0] = next_cur.ext_flag[0];
            next_cur.smp_req[SRC_EXT1] = next_cur.ext_flag[1];
            next_cur.smp_req[SRC_TMR2] = tmr2_ovf_flag | next_cur.t2pin_flag;
        end
        if (mc_end) begin
            next_cur.poll_req = cur.smp_req;
        end

        // timer rollover pulses, set wins over software clear
        if (tmr0_rollover) begin
            next_cur.tmr_flag[0] = 1'b1;
        end
        if (tmr1_rollover) begin
            next_cur.tmr_flag[1] = 1'b1;
        end
    end

    // single register stage; ce low freezes everything
    // reset puts the pin samples at the idle high level, so no false edge follows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur.phase      <= 4'h0;
            cur.sync1      <= 3'h7;
            cur.sync2      <= 3'h7;
            cur.pin_smp    <= 3'h7;
            cur.edge_sel   <= 2'h0;
            cur.ext_flag   <= 2'h0;
            cur.tmr_flag   <= 2'h0;
            cur.t2pin_en   <= 1'b0;
            cur.t2pin_flag <= 1'b0;
            cur.enable     <= RST_ENABLE;
            cur.level      <= RST_LEVEL;
            cur.smp_req    <= 6'h00;
            cur.poll_req   <= 6'h00;
            cur.inprog     <= 2'h0;
            cur.hold_off   <= 1'b0;
            cur.seq        <= TLIC_POLL;
            cur.vector     <= 16'h0000;
            cur.rdata      <= 32'h0000_0000;
        end else if (ce) begin
            cur <= next_cur;
        end
    end

    // outputs toward the cpu sequencer
    assign long_call     = (cur.seq != TLIC_POLL);
    assign call_vector   = cur.vector;
    assign machine_phase = cur.phase;
    assign in_service    = cur.inprog;

endmodule // tlic_core

`default_nettype wire

// *** verification/tlic_core_asserts.sv ***
// checker for the controller's call sequencing and level marking
// assumes one pclk domain and the port names of tlic_core
`timescale 1ns/10ps
`default_nettype none
module tlic_core_asserts
    import tlic_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // cpu side
    input  wire logic        instr_last_cycle,
    input  wire logic        return_from_irq,
    input  wire logic        long_call,
    input  wire logic [15:0] call_vector,
    input  wire logic [3:0]  machine_phase,
    input  wire logic [1:0]  in_service
);
    logic [5:0] run;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // call length counted on run edges only, so a freeze cannot stretch it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            run <= 6'h00;
        else if (!long_call)
            run <= 6'h00;
        else if (ce)
            run <= run + 6'h01;
    end
    // steps of one hardware call
    sequence call_start;
        $rose(long_call);
    endsequence
    sequence call_end;
        $fell(long_call);
    endsequence
    call_len_a: assert property (call_end |-> run == 6'h18)
        else $error("call length wrong");
    call_cap_a: assert property (long_call |-> run < 6'h18)
        else $error("call runs too long");
    call_cond_a: assert property (call_start |-> $past(machine_phase) == PHASE_LAST
        && $past(instr_last_cycle) && !$past(return_from_irq)) else $error("call out of place");
    vec_legal_a: assert property (call_start |-> call_vector inside {16'h0003, 16'h000B,
        16'h0013, 16'h001B, 16'h0023, 16'h002B}) else $error("bad vector");
    hi_block_a: assert property (call_start |-> !$past(in_service[1]))
        else $error("high routine preempted");
    preempt_hi_a: assert property ($rose(long_call) && $past(in_service[0])
        |-> in_service == 2'b11) else $error("low routine preempted by low");
    svc_ret_a: assert property ($fell(in_service[0]) || $fell(in_service[1])
        |-> $past(return_from_irq)) else $error("level cleared without return");
    phase_step_a: assert property ($past(ce) && $past(presetn) |-> machine_phase ==
        (($past(machine_phase) == PHASE_LAST) ? 4'h0 : $past(machine_phase) + 4'h1))
        else $error("phase step wrong");
endmodule // tlic_core_asserts
bind tlic_core tlic_core_asserts u_chk (
    .pclk(pclk), .presetn(presetn), .ce(ce), .instr_last_cycle(instr_last_cycle),
    .return_from_irq(return_from_irq), .long_call(long_call), .call_vector(call_vector),
    .machine_phase(machine_phase), .in_service(in_service)
);
`default_nettype wire

// *** verification/tlic_cpu_model.sv ***
// cpu sequence model: instruction boundaries and return_from_irq
// assumes machine_phase from the controller and a bench pulse on ret_req
`timescale 1ns/10ps
`default_nettype none
module tlic_cpu_model
    import tlic_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // controller side
    input  wire logic [3:0] machine_phase,
    input  wire logic       long_call,
    output logic            instr_last_cycle,
    output logic            return_from_irq,
    // bench control
    input  wire logic       ret_req,
    input  wire logic [2:0] instr_mcs
);
    logic [2:0] mc;
    logic       pend;
    // no final cycle inside the call; a return takes two cycles
    assign instr_last_cycle = !long_call &&
        mc == (return_from_irq ? 3'h1 : instr_mcs - 3'h1);
    // boundaries on the phase-11 edge; a return waits for the next one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc              <= 3'h0;
            pend            <= 1'b0;
            return_from_irq <= 1'b0;
        end else begin
            if (long_call)
                mc <= 3'h0;
            else if (machine_phase == PHASE_LAST && instr_last_cycle) begin
                mc              <= 3'h0;
                return_from_irq <= pend;
                pend            <= 1'b0;
            end else if (machine_phase == PHASE_LAST)
                mc <= mc + 3'h1;
            if (ret_req)
                pend <= 1'b1;
        end
    end
endmodule // tlic_cpu_model
`default_nettype wire

// *** verification/tlic_core_tb.sv ***
// bench for the interrupt controller: table of calls, then preemption, edge and pin cases
// assumes tlic_core, its checker bind and tlic_cpu_model are compiled before it
`timescale 1ns/10ps
`default_nettype none
module tlic_core_tb;
    import tlic_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0]  ext_request_pin, in_service, sv;
    logic        tmr2_capture_pin, tmr0_rollover, tmr1_rollover, rx_done_flag, tx_done_flag;
    logic        tmr2_ovf_flag, instr_last_cycle, return_from_irq, long_call, ret_req;
    logic [15:0] call_vector, v;
    logic [3:0]  machine_phase;
    logic [2:0]  imcs;
    logic [47:0] rows [10];
    int          num_errors, checks_done, lat, i;
    tlic_core u_dut (
        .pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_request_pin, .tmr2_capture_pin,
        .tmr0_rollover, .tmr1_rollover, .rx_done_flag, .tx_done_flag,
        .tmr2_ovf_flag, .instr_last_cycle, .return_from_irq, .long_call,
        .call_vector, .machine_phase, .in_service
    );
    tlic_cpu_model u_cpu (
        .pclk, .presetn, .machine_phase, .long_call, .instr_last_cycle,
        .return_from_irq, .ret_req, .instr_mcs(imcs)
    );
    // 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // compare, report and close
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task tmo;
        num_errors++;
        $display("mismatch wait bound expected event seen none");
        close_out();
    endtask
    // apb transfer: request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        if (k >= 40)
            tmo();
        q  = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // sources in polling order; rollovers are one-cycle pulses
    task automatic raise(input logic [5:0] m);
        @(posedge pclk);
        ext_request_pin <= ~{m[2], m[0]};
        tmr0_rollover   <= m[1];
        tmr1_rollover   <= m[3];
        rx_done_flag    <= m[4];
        tmr2_ovf_flag   <= m[5];
        @(posedge pclk);
        tmr0_rollover <= 1'b0;
        tmr1_rollover <= 1'b0;
    endtask
    task drop;
        @(posedge pclk);
        ext_request_pin <= 2'b11;
        rx_done_flag    <= 1'b0;
        tx_done_flag    <= 1'b0;
        tmr2_ovf_flag   <= 1'b0;
    endtask
    task ret;
        @(posedge pclk);
        ret_req <= 1'b1;
        @(posedge pclk);
        ret_req <= 1'b0;
    endtask
    // outputs sampled on the falling edge, where they have settled
    task automatic wait_call;
        int k;
        for (k = 0; long_call !== 1'b1; k++) begin
            if (k > 400)
                tmo();
            @(negedge pclk);
        end
        lat = k;
        v   = call_vector;
        sv  = in_service;
        for (k = 0; long_call === 1'b1; k++) begin
            if (k > 40)
                tmo();
            @(negedge pclk);
        end
        lat += k;
    endtask
    task automatic wait_isv(input logic [1:0] e);
        int k;
        for (k = 0; in_service !== e; k++) begin
            if (k > 400)
                tmo();
            @(negedge pclk);
        end
        chk("in service", e, in_service);
    endtask
    task automatic no_call(input int n);
        int k;
        for (k = 0; k < n && long_call === 1'b0; k++)
            @(negedge pclk);
        chk("no call", 32'h0, long_call);
    endtask
    // rows: sources, level, instr cycles, vector, level marked, timer_ctrl after call
    initial begin
        rows = '{48'h01_00_1_0003_1_02, 48'h02_00_1_000B_1_00, 48'h04_00_4_0013_1_08,
                 48'h08_00_4_001B_1_00, 48'h10_3F_1_0023_2_00, 48'h20_3F_4_002B_2_00,
                 48'h3F_00_1_0003_1_AA, 48'h3F_20_1_002B_2_AA, 48'h3A_00_1_000B_1_80,
                 48'h0C_04_1_0013_2_88};
        {psel, penable, pwrite, paddr, pwdata, ret_req} = '0;
        {tmr0_rollover, tmr1_rollover, rx_done_flag, tx_done_flag, tmr2_ovf_flag} = '0;
        ext_request_pin  = 2'b11;
        tmr2_capture_pin = 1'b1;
        imcs             = 3'h1;
        presetn          = 1'b0;
        num_errors       = 0;
        checks_done      = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 24; i += 4) begin
            apb(1'b0, i[7:0], 32'h0);
            chk("reset word", 32'h0, q);
            chk("slave error", i == 20, se);
        end
        $display("test reset done");
        wr(OFS_ENABLE, 32'hBF);
        foreach (rows[r]) begin
            imcs <= rows[r][30:28];
            wr(OFS_LEVEL, {24'h0, rows[r][39:32]});
            repeat (48) @(posedge pclk);
            raise(rows[r][45:40]);
            wait_call();
            chk("vector", rows[r][27:12], v);
            chk("level", rows[r][9:8], sv);
            chk("latency", 1, lat > 36 && lat < 108);
            apb(1'b0, OFS_TCTRL, 32'h0);
            chk("timer ctrl", rows[r][7:0], q);
            drop();
            wr(OFS_TCTRL, 32'h0);
            ret();
            wait_isv(2'b00);
            $display("test row %0d done", r);
        end
        // low routine, low refused, high preempts, blocked pin pulse forgotten
        wr(OFS_LEVEL, 32'h08);
        repeat (48) @(posedge pclk);
        raise(6'h02);
        wait_call();
        chk("low call", 16'h000B, v);
        @(posedge pclk);
        tx_done_flag <= 1'b1;
        no_call(60);
        raise(6'h08);
        wait_call();
        chk("preempt", 2'b11, sv);
        @(posedge pclk);
        ext_request_pin <= 2'b10;
        repeat (24) @(posedge pclk);
        ext_request_pin <= 2'b11;
        ret();
        wait_isv(2'b01);
        no_call(60);
        ret();
        wait_call();
        chk("after return", 16'h0023, v);
        drop();
        ret();
        wait_isv(2'b00);
        $display("test preempt done");
        // falling edge request, flag cleared on vectoring, no retrigger while low
        wr(OFS_TCTRL, 32'h04);
        raise(6'h04);
        wait_call();
        chk("edge call", 16'h0013, v);
        apb(1'b0, OFS_TCTRL, 32'h0);
        chk("edge flag", 32'h04, q);
        ret();
        wait_isv(2'b00);
        no_call(60);
        drop();
        $display("test edge done");
        // timer 2 pin event gated by its enable; global enable off holds it
        wr(OFS_ENABLE, 32'h3F);
        for (i = 0; i < 2; i++) begin
            wr(OFS_T2CTRL, i);
            tmr2_capture_pin <= 1'b0;
            repeat (24) @(posedge pclk);
            tmr2_capture_pin <= 1'b1;
            repeat (24) @(posedge pclk);
            apb(1'b0, OFS_T2CTRL, 32'h0);
            chk("pin event", 3 * i, q);
        end
        no_call(60);
        wr(OFS_ENABLE, 32'hBF);
        wait_call();
        chk("pin call", 16'h002B, v);
        wr(OFS_T2CTRL, 32'h0);
        ret();
        wait_isv(2'b00);
        $display("test pin done");
        close_out();
    end
endmodule // tlic_core_tb
`default_nettype wire
